// ==== verilog/lsb_pkg.sv ====
// shared constants for the latching scaler bank
package lsb_pkg;
    // ------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------
    localparam int CHANNELS    = 32;
    localparam int CNT_W       = 12;
    localparam int CE_W        = 20;
    localparam int ADDR_W      = 20;
    localparam int PTR_W       = 21;
    localparam int DW_W        = 24;
    localparam int MODS_W      = 5;
    localparam int MODULE_SH   = 15;  // 32k words per memory module

    localparam logic [CNT_W-1:0] CNT_ZERO = 12'h000;
    localparam logic [CNT_W-1:0] CNT_FULL = 12'hFFF;
    localparam logic [CE_W-1:0]  CE_ZERO  = 20'h00000;

    // ------------------------------------------------------------
    // timing (50 MHz reference clock)
    // ------------------------------------------------------------
    localparam int CLK_NS          = 20;
    localparam int MIN_PULSE_NS    = 160;
    localparam int MIN_PULSE_CYC   = (MIN_PULSE_NS + CLK_NS - 1) / CLK_NS;
    localparam int MIN_WINDOW_US   = 50;
    localparam int MIN_WINDOW_CYC  = (MIN_WINDOW_US * 1000 + CLK_NS - 1) / CLK_NS;
    localparam int MIN_GAP_US      = 1;
    localparam int MIN_GAP_CYC     = (MIN_GAP_US * 1000 + CLK_NS - 1) / CLK_NS;

    // ------------------------------------------------------------
    // dataway function and subaddress codes
    // ------------------------------------------------------------
    localparam logic [4:0] F_READ     = 5'h00;
    localparam logic [4:0] F_READ_ID  = 5'h06;
    localparam logic [4:0] F_READBACK = 5'h11;
    localparam logic [4:0] F_STANDBY  = 5'h18;
    localparam logic [4:0] F_ARM      = 5'h1A;
    localparam logic [3:0] A_DATA     = 4'h0;
    localparam logic [3:0] A_CE_CNT   = 4'h1;
    localparam logic [3:0] A_STATUS   = 4'h2;
    localparam logic [3:0] A_MEMORY   = 4'h3;
    localparam logic [3:0] A_CHANNELS = 4'h4;
    localparam logic [3:0] A_MAX_MULT = 4'h8;

    // status word field positions
    localparam int ST_MODE_LO = 0;
    localparam int ST_WRAP    = 2;
    localparam int ST_FULL    = 3;
    localparam logic [1:0] ST_STANDBY  = 2'h0;
    localparam logic [1:0] ST_ARMED    = 2'h1;
    localparam logic [1:0] ST_READBACK = 2'h2;

    // module identity, value arbitrary
    localparam logic [DW_W-1:0] MODULE_ID = 24'h00A5C3;

    typedef enum logic [2:0] {
        LSB_STANDBY  = 3'b001,
        LSB_ARMED    = 3'b010,
        LSB_READBACK = 3'b100
    } lsb_mode_e;
endpackage

// ==== verilog/lsb_chan_counter.sv ====
// one twelve-bit scaler channel with input synchroniser
`timescale 1ns/100ps
module lsb_chan_counter
(
    // clock and reset
    input  wire logic                       ref_clk,
    input  wire logic                       srst,
    // control
    input  wire logic                       pulse_in,
    input  wire logic                       count_en,
    input  wire logic                       clear,
    input  wire logic                       wrap_en,
    // result
    output logic [lsb_pkg::CNT_W-1:0]       count_ff
);
    logic sync1_ff;
    logic sync2_ff;
    logic prev_ff;
    logic rise;

    // ------------------------------------------------------------
    // synchroniser and edge detect
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            sync1_ff <= 1'b0;
            sync2_ff <= 1'b0;
            prev_ff  <= 1'b0;
        end
        else
        begin
            sync1_ff <= pulse_in;
            sync2_ff <= sync1_ff;
            prev_ff  <= sync2_ff;
        end
    end

    // a 160 ns pulse spans eight clocks, so no edge is missed
    assign rise = sync2_ff & ~prev_ff;

    // ------------------------------------------------------------
    // counter
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk)
    begin
        if (srst || clear)
            count_ff <= lsb_pkg::CNT_ZERO;
        else if (count_en && rise)
        begin
            if (count_ff != lsb_pkg::CNT_FULL)
                count_ff <= count_ff + 12'h001;
            else if (wrap_en)
                count_ff <= lsb_pkg::CNT_ZERO;
        end
    end
endmodule // lsb_chan_counter

// ==== verilog/lsb_scaler.sv ====
// latching scaler bank: mode control, window gating, memory streaming, dataway
`timescale 1ns/100ps
// Behaviour
// - each channel counter holds twelve binary bits
// - plain binary count; all ones means 4095 or more without wrap
// - with wrap selected, all ones goes to zero on pulse 4096
// - one wrap switch serves every channel
// - wrap switch shows as a status word bit
// - sample window gates all 32 channels together
// - sample window ignored outside armed mode
// - count pulses down to 160 ns, rates up to 4 MHz
// - one to 32 memory modules, up to a megaword of twelve bits
// - module count comes from a switch and reads back at subaddress A_MEMORY
// - memory shared among channels by active channel count
// - always exactly one mode: standby, armed or readback
// - standby at reset, dataway clear or initialize, standby command
// - count inputs ignored in standby
// - readback request in standby refused with Q=0
// - armed mode stores words in channel order from location zero
// - armed only: 20-bit counter of window closing edges (window_n rising)
// - memory end stops counting and windows, no wrap, full bit set
// - count inputs ignored in readback
module lsb_scaler
(
    // clock and reset
    input  wire logic                            ref_clk,
    input  wire logic                            srst,
    // front panel inputs
    input  wire logic [lsb_pkg::CHANNELS-1:0]    pulse_in,
    input  wire logic                            window_n,
    // board switches
    input  wire logic                            sw_wrap,
    input  wire logic [lsb_pkg::MODS_W-1:0]      sw_mem_mods,
    input  wire logic [lsb_pkg::MODS_W-1:0]      sw_active_ch,
    // dataway command
    input  wire logic                            dw_clear,
    input  wire logic                            cmd_valid,
    input  wire logic [4:0]                      cmd_func,
    input  wire logic [3:0]                      cmd_sub,
    input  wire logic [lsb_pkg::DW_W-1:0]        cmd_wdata,
    // dataway answer
    output logic                                 rsp_valid_ff,
    output logic                                 rsp_q_ff,
    output logic                                 rsp_x_ff,
    output logic [lsb_pkg::DW_W-1:0]             rsp_rdata_ff,
    // external memory
    output logic                                 mem_wr_en,
    output logic                                 mem_rd_en,
    output logic [lsb_pkg::ADDR_W-1:0]           mem_addr,
    output logic [lsb_pkg::CNT_W-1:0]            mem_wdata,
    input  wire logic [lsb_pkg::CNT_W-1:0]       mem_rdata
);
    lsb_pkg::lsb_mode_e            mode_ff;
    logic                          win_s1_ff;
    logic                          win_s2_ff;
    logic                          win_prev_ff;
    logic                          win_end;
    logic                          gate;
    logic                          full_ff;
    logic [lsb_pkg::CE_W-1:0]      ce_cnt_ff;
    logic [lsb_pkg::CNT_W-1:0]     shadow_ff [lsb_pkg::CHANNELS];
    logic [lsb_pkg::CNT_W-1:0]     count     [lsb_pkg::CHANNELS];
    logic                          wr_busy_ff;
    logic [4:0]                    wr_idx_ff;
    logic [lsb_pkg::PTR_W-1:0]     wr_ptr_ff;
    logic [lsb_pkg::PTR_W-1:0]     rd_ptr_ff;
    logic [8:0]                    rd_step_ff;
    logic [5:0]                    n_act;
    logic [5:0]                    n_mods;
    logic [lsb_pkg::PTR_W-1:0]     mem_size;
    logic                          is_rb_data;
    logic                          rb_ok;
    logic                          latch;
    logic                          clr_counters;

    localparam int PTR_W = lsb_pkg::PTR_W;

    // ------------------------------------------------------------
    // switch decode: a zero setting stands for 32
    // ------------------------------------------------------------
    assign n_act    = (sw_active_ch == 5'h00) ? 6'h20 : {1'b0, sw_active_ch};
    assign n_mods   = (sw_mem_mods == 5'h00) ? 6'h20 : {1'b0, sw_mem_mods};
    assign mem_size = PTR_W'({n_mods, 15'h0000});

    // ------------------------------------------------------------
    // mode control
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk)
    begin
        if (srst || dw_clear)
            mode_ff <= lsb_pkg::LSB_STANDBY;
        else if (cmd_valid)
        begin
            case (cmd_func)
                lsb_pkg::F_STANDBY:  mode_ff <= lsb_pkg::LSB_STANDBY;
                lsb_pkg::F_ARM:      mode_ff <= lsb_pkg::LSB_ARMED;
                lsb_pkg::F_READBACK: mode_ff <= lsb_pkg::LSB_READBACK;
                default:             mode_ff <= mode_ff;
            endcase
        end
    end

    // ------------------------------------------------------------
    // sample window
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            win_s1_ff   <= 1'b1;
            win_s2_ff   <= 1'b1;
            win_prev_ff <= 1'b1;
        end
        else
        begin
            win_s1_ff   <= window_n;
            win_s2_ff   <= win_s1_ff;
            win_prev_ff <= win_s2_ff;
        end
    end

    // window closing only matters when armed and memory has room
    assign win_end = (mode_ff == lsb_pkg::LSB_ARMED) && !full_ff
                     && win_s2_ff && !win_prev_ff;
    // one gate for all channels; standby and readback never count
    assign gate    = (mode_ff == lsb_pkg::LSB_ARMED) && !full_ff && !win_s2_ff;
    // a window end while the previous set still drains is not latched; the 1 us gap covers it
    assign latch   = win_end && !wr_busy_ff;
    assign clr_counters = latch || (mode_ff != lsb_pkg::LSB_ARMED);

    always_ff @(posedge ref_clk)
    begin
        if (srst || dw_clear)
            ce_cnt_ff <= lsb_pkg::CE_ZERO;
        else if (cmd_valid && (cmd_func == lsb_pkg::F_STANDBY
                               || cmd_func == lsb_pkg::F_ARM))
            ce_cnt_ff <= lsb_pkg::CE_ZERO;
        else if (win_end)
            ce_cnt_ff <= ce_cnt_ff + 20'h00001;
    end

    // ------------------------------------------------------------
    // channel counters and latch
    // ------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < lsb_pkg::CHANNELS; gi++)
        begin : g_chan
            lsb_chan_counter u_cnt
            (
                .ref_clk  (ref_clk),
                .srst     (srst),
                .pulse_in (pulse_in[gi]),
                .count_en (gate),
                .clear    (clr_counters),
                .wrap_en  (sw_wrap),
                .count_ff (count[gi])
            );

            always_ff @(posedge ref_clk)
            begin
                if (srst)
                    shadow_ff[gi] <= lsb_pkg::CNT_ZERO;
                else if (latch)
                    shadow_ff[gi] <= count[gi];
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // memory writer: active channels in order, one word a clock
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk)
    begin
        if (srst || dw_clear
            || (cmd_valid && (cmd_func == lsb_pkg::F_STANDBY
                              || cmd_func == lsb_pkg::F_ARM)))
        begin
            wr_busy_ff <= 1'b0;
            wr_idx_ff  <= 5'h00;
            wr_ptr_ff  <= '0;
            full_ff    <= 1'b0;
        end
        else if (wr_busy_ff)
        begin
            wr_ptr_ff <= wr_ptr_ff + 21'h000001;
            if (wr_ptr_ff + 21'h000001 >= mem_size)
            begin
                // no wrap: the rest of the set is dropped
                full_ff    <= 1'b1;
                wr_busy_ff <= 1'b0;
            end
            else if ({1'b0, wr_idx_ff} == n_act - 6'h01)
                wr_busy_ff <= 1'b0;
            wr_idx_ff <= wr_idx_ff + 5'h01;
        end
        else if (latch)
        begin
            wr_busy_ff <= 1'b1;
            wr_idx_ff  <= 5'h00;
        end
    end

    assign mem_wr_en = wr_busy_ff;
    assign mem_wdata = shadow_ff[wr_idx_ff];
    assign mem_addr  = wr_busy_ff ? wr_ptr_ff[lsb_pkg::ADDR_W-1:0]
                                  : rd_ptr_ff[lsb_pkg::ADDR_W-1:0];

    // ------------------------------------------------------------
    // readback pointer
    // ------------------------------------------------------------
    assign is_rb_data = cmd_valid && cmd_func == lsb_pkg::F_READ
                        && cmd_sub == lsb_pkg::A_DATA;
    assign rb_ok      = (mode_ff == lsb_pkg::LSB_READBACK) && (rd_ptr_ff < mem_size);
    assign mem_rd_en  = is_rb_data && rb_ok;

    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            rd_ptr_ff  <= '0;
            rd_step_ff <= 9'h001;
        end
        else if (cmd_valid && cmd_func == lsb_pkg::F_READBACK)
        begin
            rd_ptr_ff <= {1'b0, cmd_wdata[lsb_pkg::ADDR_W-1:0]};
            if (cmd_sub == 4'h0)
                rd_step_ff <= 9'h001;
            else if (cmd_sub > lsb_pkg::A_MAX_MULT)
                rd_step_ff <= {3'h0, n_act};
            else
                rd_step_ff <= 9'(cmd_sub * n_act);
        end
        else if (mem_rd_en)
            rd_ptr_ff <= rd_ptr_ff + {12'h000, rd_step_ff};
    end

    // ------------------------------------------------------------
    // dataway answer, one clock after the command
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            rsp_valid_ff <= 1'b0;
            rsp_q_ff     <= 1'b0;
            rsp_x_ff     <= 1'b0;
            rsp_rdata_ff <= '0;
        end
        else
        begin
            rsp_valid_ff <= cmd_valid;
            rsp_q_ff     <= 1'b0;
            rsp_x_ff     <= 1'b0;
            rsp_rdata_ff <= '0;
            if (cmd_valid)
            begin
                rsp_x_ff <= 1'b1;
                case (cmd_func)
                    lsb_pkg::F_STANDBY, lsb_pkg::F_ARM, lsb_pkg::F_READBACK:
                        rsp_q_ff <= 1'b1;
                    lsb_pkg::F_READ_ID:
                    begin
                        rsp_q_ff     <= 1'b1;
                        rsp_rdata_ff <= lsb_pkg::MODULE_ID;
                    end
                    lsb_pkg::F_READ:
                    begin
                        rsp_q_ff <= 1'b1;
                        case (cmd_sub)
                            lsb_pkg::A_DATA:
                            begin
                                // refused with Q=0 outside readback
                                rsp_q_ff     <= rb_ok;
                                rsp_rdata_ff <= rb_ok ? {12'h000, mem_rdata} : '0;
                            end
                            lsb_pkg::A_CE_CNT:
                                rsp_rdata_ff <= {4'h0, ce_cnt_ff};
                            lsb_pkg::A_STATUS:
                            begin
                                rsp_rdata_ff[lsb_pkg::ST_MODE_LO +: 2] <=
                                    (mode_ff == lsb_pkg::LSB_ARMED) ? lsb_pkg::ST_ARMED :
                                    (mode_ff == lsb_pkg::LSB_READBACK) ?
                                        lsb_pkg::ST_READBACK : lsb_pkg::ST_STANDBY;
                                rsp_rdata_ff[lsb_pkg::ST_WRAP] <= sw_wrap;
                                rsp_rdata_ff[lsb_pkg::ST_FULL] <= full_ff;
                            end
                            lsb_pkg::A_MEMORY:
                                rsp_rdata_ff <= {19'h00000, sw_mem_mods};
                            lsb_pkg::A_CHANNELS:
                                rsp_rdata_ff <= {19'h00000, sw_active_ch};
                            default:
                            begin
                                rsp_q_ff <= 1'b0;
                                rsp_x_ff <= 1'b0;
                            end
                        endcase
                    end
                    default:
                        rsp_x_ff <= 1'b0;
                endcase
            end
        end
    end
endmodule // lsb_scaler

// ==== tb/lsb_mem_model.sv ====
// external word memory seen by the scaler, one 32k module deep
`timescale 1ns/100ps
module lsb_mem_model
(
    // clock
    input  wire logic                         ref_clk,
    // scaler side
    input  wire logic                         mem_wr_en,
    input  wire logic [lsb_pkg::ADDR_W-1:0]   mem_addr,
    input  wire logic [lsb_pkg::CNT_W-1:0]    mem_wdata,
    output logic [lsb_pkg::CNT_W-1:0]         mem_rdata
);
    logic [11:0] words [32768];
    logic        seen  [32768] = '{default: 1'b0};

    // unwritten words read as an address pattern, so a stale value never passes
    always_comb
        mem_rdata = seen[mem_addr[14:0]] ? words[mem_addr[14:0]] : (mem_addr[11:0] ^ 12'hA5A);

    always @(posedge ref_clk)
        if (mem_wr_en)
        begin
            words[mem_addr[14:0]] <= mem_wdata;
            seen[mem_addr[14:0]]  <= 1'b1;
        end
endmodule // lsb_mem_model

// ==== tb/lsb_scaler_asserts.sv ====
// port-level assertions for the latching scaler
`timescale 1ns/100ps
module lsb_scaler_asserts
(
    // clock and reset
    input wire logic                        ref_clk,
    input wire logic                        srst,
    // switches and commands
    input wire logic                        sw_wrap,
    input wire logic [lsb_pkg::MODS_W-1:0]  sw_mem_mods,
    input wire logic [lsb_pkg::MODS_W-1:0]  sw_active_ch,
    input wire logic                        dw_clear,
    input wire logic                        cmd_valid,
    input wire logic [4:0]                  cmd_func,
    input wire logic [3:0]                  cmd_sub,
    // answers and memory
    input wire logic                        rsp_valid_ff,
    input wire logic                        rsp_q_ff,
    input wire logic                        rsp_x_ff,
    input wire logic [lsb_pkg::DW_W-1:0]    rsp_rdata_ff,
    input wire logic                        mem_rd_en,
    input wire logic                        mem_wr_en,
    input wire logic [lsb_pkg::ADDR_W-1:0]  mem_addr
);
    logic [1:0] mode_ff;
    logic [5:0] wr_run_ff;
    logic       rd_any;

    assign rd_any = cmd_valid && cmd_func == lsb_pkg::F_READ;

    // mode as the commands imply it, to judge answers against
    always_ff @(posedge ref_clk)
        if (srst || dw_clear)
            mode_ff <= lsb_pkg::ST_STANDBY;
        else if (cmd_valid && cmd_func == lsb_pkg::F_STANDBY)
            mode_ff <= lsb_pkg::ST_STANDBY;
        else if (cmd_valid && cmd_func == lsb_pkg::F_ARM)
            mode_ff <= lsb_pkg::ST_ARMED;
        else if (cmd_valid && cmd_func == lsb_pkg::F_READBACK)
            mode_ff <= lsb_pkg::ST_READBACK;

    always_ff @(posedge ref_clk)
        if (srst || !mem_wr_en)
            wr_run_ff <= 6'h00;
        else
            wr_run_ff <= wr_run_ff + 6'h01;

    default clocking @(posedge ref_clk); endclocking
    default disable iff (srst);

    a_rsp_follows: assert property (cmd_valid |=> rsp_valid_ff)
        else $error("command got no answer");
    a_rsp_quiet: assert property (!rsp_valid_ff
        |-> !rsp_q_ff && !rsp_x_ff && rsp_rdata_ff == 24'h0)
        else $error("answer lines busy without answer");
    a_status_mode: assert property (rd_any && cmd_sub == lsb_pkg::A_STATUS
        |=> rsp_rdata_ff[1:0] == $past(mode_ff))
        else $error("status mode field wrong");
    a_status_wrap: assert property (rd_any && cmd_sub == lsb_pkg::A_STATUS
        |=> rsp_rdata_ff[2] == $past(sw_wrap) && rsp_rdata_ff[23:4] == 20'h0)
        else $error("status wrap bit wrong");
    a_mods_report: assert property (rd_any && cmd_sub == lsb_pkg::A_MEMORY
        |=> rsp_rdata_ff == {19'h0, $past(sw_mem_mods)})
        else $error("memory module count wrong");
    a_readback_refused: assert property (rd_any && cmd_sub == lsb_pkg::A_DATA
        && mode_ff != lsb_pkg::ST_READBACK
        |=> !rsp_q_ff && rsp_x_ff && rsp_rdata_ff == 24'h0)
        else $error("readback outside readback mode");
    a_read_strobe: assert property (mem_rd_en
        |-> rd_any && cmd_sub == lsb_pkg::A_DATA
            && mode_ff == lsb_pkg::ST_READBACK ##1 rsp_q_ff)
        else $error("memory read strobe without accepted readback");
    a_write_armed: assert property (mem_wr_en |-> mode_ff == lsb_pkg::ST_ARMED)
        else $error("memory write outside armed mode");
    a_write_order: assert property (mem_wr_en && $past(mem_wr_en)
        |-> mem_addr == $past(mem_addr) + 20'h1)
        else $error("write address not consecutive");
    a_burst_len: assert property ($fell(mem_wr_en)
        |-> wr_run_ff == (sw_active_ch == 5'h00 ? 6'h20 : {1'b0, sw_active_ch}))
        else $error("write burst length wrong");
endmodule // lsb_scaler_asserts

bind lsb_scaler lsb_scaler_asserts u_lsb_chk
(
    .ref_clk, .srst, .sw_wrap, .sw_mem_mods, .sw_active_ch, .dw_clear, .cmd_valid, .cmd_func,
    .cmd_sub, .rsp_valid_ff, .rsp_q_ff, .rsp_x_ff, .rsp_rdata_ff, .mem_wr_en, .mem_addr,
    .mem_rd_en
);

// ==== tb/latching_scaler_bank_tb.sv ====
// self-checking bench for the latching scaler bank
`timescale 1ns/100ps
module latching_scaler_bank_tb;
    logic        ref_clk = 1'b0;
    logic        srst = 1'b1;
    logic [31:0] pulse_in = 32'h0;
    logic        window_n = 1'b1;
    logic        sw_wrap = 1'b1;
    logic [4:0]  sw_mem_mods = 5'h01;
    logic [4:0]  sw_active_ch = 5'h00;
    logic        dw_clear = 1'b0;
    logic        cmd_valid = 1'b0;
    logic [4:0]  cmd_func = 5'h00;
    logic [3:0]  cmd_sub = 4'h0;
    logic [23:0] cmd_wdata = 24'h0;
    logic        rsp_valid_ff, rsp_q_ff, rsp_x_ff, mem_wr_en, mem_rd_en, rq, rx;
    logic [23:0] rsp_rdata_ff, rd;
    logic [19:0] mem_addr;
    logic [11:0] mem_wdata, mem_rdata;
    logic [11:0] ex [32];
    int          n1 [32], n2 [32], z [32], s;
    int          n_fail = 0;
    int          total_checks = 0;

    always #10 ref_clk = ~ref_clk;

    lsb_scaler dut (.ref_clk, .srst, .pulse_in, .window_n, .sw_wrap, .sw_mem_mods, .sw_active_ch,
        .dw_clear, .cmd_valid, .cmd_func, .cmd_sub, .cmd_wdata, .rsp_valid_ff, .rsp_q_ff,
        .rsp_x_ff, .rsp_rdata_ff, .mem_wr_en, .mem_rd_en, .mem_addr, .mem_wdata, .mem_rdata);
    lsb_mem_model u_mem (.ref_clk, .mem_wr_en, .mem_addr, .mem_wdata, .mem_rdata);

    function automatic logic [11:0] exp_cnt(input int a, input int b);
        int c;
        c = a % 4096;
        c = (c + b > 4095) ? 4095 : c + b;
        return c[11:0];
    endfunction

    function automatic logic [11:0] exp_word(input int a);
        return (a < 32) ? ex[a] : (a[11:0] ^ 12'hA5A);
    endfunction

    function automatic int step_of(input int n);
        return (n == 0) ? 1 : (n > 8) ? 5 : n * 5;
    endfunction

    task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
        total_checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic cmd(input logic [4:0] f, input logic [3:0] a, input logic [23:0] wd);
        @(posedge ref_clk);
        #1;
        cmd_valid = 1'b1;
        cmd_func = f;
        cmd_sub = a;
        cmd_wdata = wd;
        @(posedge ref_clk);
        #1;
        cmd_valid = 1'b0;
        rq = rsp_q_ff;
        rx = rsp_x_ff;
        rd = rsp_rdata_ff;
        chk("rsp_valid", 24'h1, {23'h0, rsp_valid_ff});
    endtask

    task automatic rdreg(input logic [3:0] a, input logic [23:0] exp, input string what);
        cmd(lsb_pkg::F_READ, a, 24'h0);
        chk(what, exp, rd);
    endtask

    task automatic rdw(input int a, input bit ok);
        cmd(lsb_pkg::F_READ, lsb_pkg::A_DATA, 24'h0);
        chk("q", {23'h0, ok}, {23'h0, rq});
        chk("x", 24'h1, {23'h0, rx});
        chk("word", ok ? {12'h0, exp_word(a)} : 24'h0, rd);
    endtask

    // pulses 8 clocks high, 4 low: about 4.17 MHz, past the fastest rate
    task automatic pulse_run(input int cnt[32]);
        int          top;
        logic [31:0] m;
        top = 0;
        foreach (cnt[i]) if (cnt[i] > top) top = cnt[i];
        for (int k = 0; k < top; k++)
        begin
            foreach (cnt[i]) m[i] = cnt[i] > k;
            pulse_in = m;
            repeat (8) @(posedge ref_clk);
            #1 pulse_in = 32'h0;
            repeat (4) @(posedge ref_clk);
            #1;
        end
    endtask

    // wrap switch drops between the two pulse phases
    task automatic window(input int a[32], input int b[32]);
        @(posedge ref_clk);
        #1 window_n = 1'b0;
        repeat (4) @(posedge ref_clk);
        #1;
        pulse_run(a);
        sw_wrap = 1'b0;
        pulse_run(b);
        repeat (lsb_pkg::MIN_WINDOW_CYC) @(posedge ref_clk);
        #1 window_n = 1'b1;
        repeat (lsb_pkg::MIN_GAP_CYC + 20) @(posedge ref_clk);
    endtask

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    initial
    begin
        void'($urandom(27));
        foreach (z[i]) z[i] = 0;
        repeat (4) @(posedge ref_clk);
        #1 srst = 1'b0;
        rdreg(lsb_pkg::A_STATUS, {21'h0, sw_wrap, 2'h0}, "status");
        cmd(lsb_pkg::F_READ_ID, 4'h0, 24'h0);
        chk("module_id", lsb_pkg::MODULE_ID, rd);
        cmd(lsb_pkg::F_READ, 4'h5, 24'h0);
        chk("bad_sub_qx", 24'h0, {22'h0, rq, rx});
        rdw(0, 1'b0);
        foreach (n1[i]) n1[i] = 3;
        window(n1, z);
        rdreg(lsb_pkg::A_CE_CNT, 24'h0, "ce_count");
        $display("test standby done");
        cmd(lsb_pkg::F_ARM, 4'h0, 24'h0);
        rdreg(lsb_pkg::A_STATUS, {21'h0, sw_wrap, 2'h1}, "status");
        foreach (n1[i])
        begin
            n1[i] = $urandom_range(4097);
            n2[i] = $urandom_range(3);
        end
        n1[0] = 4097;
        n1[1] = 4096;
        n1[2] = 4095;
        n1[3] = 4094;
        n2[1] = 0;
        n2[2] = 2;
        n2[3] = 0;
        sw_wrap = 1'b1;
        window(n1, n2);
        foreach (ex[i]) ex[i] = exp_cnt(n1[i], n2[i]);
        rdreg(lsb_pkg::A_CE_CNT, 24'h1, "ce_count");
        rdreg(lsb_pkg::A_STATUS, 24'h1, "status");
        cmd(lsb_pkg::F_READBACK, 4'h0, 24'h0);
        for (int i = 0; i < 32; i++) rdw(i, 1'b1);
        $display("test overflow done");
        sw_active_ch = 5'h05;
        cmd(lsb_pkg::F_ARM, 4'h0, 24'h0);
        foreach (n1[i]) n1[i] = $urandom_range(20);
        window(n1, z);
        for (int i = 0; i < 5; i++) ex[i] = exp_cnt(n1[i], 0);
        rdreg(lsb_pkg::A_CHANNELS, 24'h5, "active");
        for (int n = 0; n < 16; n++)
        begin
            s = $urandom_range(40);
            cmd(lsb_pkg::F_READBACK, n[3:0], s[23:0]);
            rdw(s, 1'b1);
            rdw(s + step_of(n), 1'b1);
        end
        $display("test readback done");
        rdreg(lsb_pkg::A_MEMORY, 24'h1, "mem_mods");
        cmd(lsb_pkg::F_READBACK, 4'h0, 24'h007FFF);
        rdw(32767, 1'b1);
        rdw(32768, 1'b0);
        window(n1, z);
        rdreg(lsb_pkg::A_CE_CNT, 24'h1, "ce_count");
        $display("test memory end done");
        cmd(lsb_pkg::F_STANDBY, 4'h0, 24'h0);
        rdreg(lsb_pkg::A_CE_CNT, 24'h0, "ce_count");
        cmd(lsb_pkg::F_ARM, 4'h0, 24'h0);
        rdw(0, 1'b0);
        @(posedge ref_clk);
        #1 dw_clear = 1'b1;
        @(posedge ref_clk);
        #1 dw_clear = 1'b0;
        rdreg(lsb_pkg::A_STATUS, 24'h0, "status");
        $display("test clear done");
        tally_and_finish;
    end

    // run needs about 61k clocks; 90k leaves margin and stays in budget
    initial
    begin
        #1800000;
        n_fail++;
        tally_and_finish;
    end
endmodule // latching_scaler_bank_tb
